// [io_port_bank.sv]
// One six-bit port: pin synchroniser, output latch, direction register and pad drive
`include "six_bit_io_consts.svh"
module io_port_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  port_ctl_if.port bus,
  input wire six_bit_io_pkg::pins_t pad_i,
  output six_bit_io_pkg::pins_t pad_o,
  output six_bit_io_pkg::pins_t pad_oe_o
);
  six_bit_io_pkg::pins_t meta;
  six_bit_io_pkg::pins_t sync;

  // =====================================
  // Pin synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= pad_i;
      sync <= meta;
    end
  end
  assign bus.pins = sync;

  // =====================================
  // Output latch, kept until rewritten
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.latch <= `LATCH_RESET;
    end else if (bus.wr) begin
      bus.latch <= bus.wdata;
    end
  end

  // =====================================
  // Direction register, write-only from the core
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.dir <= `DIR_RESET;
    end else if (bus.dir_rst) begin
      bus.dir <= `DIR_RESET;
    end else if (bus.dir_wr) begin
      bus.dir <= bus.dir_data;
    end
  end

  assign pad_o = bus.latch;
  assign pad_oe_o = ~bus.dir & ~bus.force_in;
endmodule : io_port_bank

// [pin_wake_detect.sv]
// Wake-on-change detector: snapshots the group at sleep entry, pulses on a difference
module pin_wake_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sleep_i,
  input wire six_bit_io_pkg::pins_t mask_i,
  input wire six_bit_io_pkg::pins_t pins_i,
  output logic wake_o
);
  six_bit_io_pkg::wake_state_t state;
  six_bit_io_pkg::pins_t snap;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= six_bit_io_pkg::WK_IDLE;
      snap <= '0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      case (state)
        six_bit_io_pkg::WK_IDLE: begin
          if (sleep_i) begin
            snap <= pins_i;
            state <= six_bit_io_pkg::WK_ARMED;
          end
        end
        six_bit_io_pkg::WK_ARMED: begin
          if (!sleep_i) begin
            state <= six_bit_io_pkg::WK_IDLE;
          end else if (((pins_i ^ snap) & mask_i) != '0) begin
            wake_o <= 1'b1;
            state <= six_bit_io_pkg::WK_IDLE;
          end
        end
        default: begin
          state <= six_bit_io_pkg::WK_IDLE;
        end
      endcase
    end
  end
endmodule : pin_wake_detect

// [pin_world.sv]
// Behavioural model of the circuitry wired to one six-bit port
module pin_world (
  input wire logic clk_i,
  input wire logic [5:0] drv_i,
  input wire logic [5:0] oe_i,
  input wire logic [5:0] pu_i,
  input wire logic [5:0] ext_val_i,
  input wire logic [5:0] ext_en_i,
  output logic [5:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven pad without pull-up wanders every cycle
  logic [5:0] flt = 6'h15;
  always_ff @(posedge clk_i) begin
    flt <= ~flt;
  end
  // External drive wins over the port driver, as a strong load would
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (ext_en_i[i]) begin
        pad_o[i] = ext_val_i[i];
      end else if (oe_i[i]) begin
        pad_o[i] = drv_i[i];
      end else if (pu_i[i]) begin
        pad_o[i] = 1'b1;
      end else begin
        pad_o[i] = flt[i];
      end
    end
  end
endmodule : pin_world

// [port_ctl_if.sv]
// Control and pin-level signals between the port block and one port bank
interface port_ctl_if;
  logic wr;
  six_bit_io_pkg::pins_t wdata;
  logic dir_wr;
  six_bit_io_pkg::pins_t dir_data;
  logic dir_rst;
  six_bit_io_pkg::pins_t force_in;
  six_bit_io_pkg::pins_t pins;
  six_bit_io_pkg::pins_t latch;
  six_bit_io_pkg::pins_t dir;
  modport ctl(output wr, wdata, dir_wr, dir_data, dir_rst, force_in, input pins, latch, dir);
  modport port(input wr, wdata, dir_wr, dir_data, dir_rst, force_in, output pins, latch, dir);
endinterface : port_ctl_if

// [six_bit_io_consts.svh]
// Offsets, field positions, reset values and selector codes of the I/O port block
`ifndef SIX_BIT_IO_CONSTS_SVH
`define SIX_BIT_IO_CONSTS_SVH
`define PORT_W 6
`define ADDR_STATUS 5'h03
`define ADDR_FIRST_PORT 5'h06
`define ADDR_SECOND_PORT 5'h07
`define DIR_SEL_FIRST 3'h6
`define DIR_SEL_SECOND 3'h7
`define DIR_RESET 6'h3F
`define LATCH_RESET 6'h00
`define OPT_RESET 8'hFF
`define OPT_WAKE_DIS 7
`define OPT_PULLUP_DIS 6
`define OPT_T0CS 5
`define STAT_WAKE_BIT 7
`define GROUP_LARGE 6'h1B
`define GROUP_SMALL 6'h0B
`define PIN_THREE 3
`define PIN_FIVE 5
`endif

// [six_bit_io_pkg.sv]
// Shared types of the I/O port block
package six_bit_io_pkg;
  typedef logic [5:0] pins_t;
  typedef enum logic {WK_IDLE, WK_ARMED} wake_state_t;
endpackage : six_bit_io_pkg

// [six_bit_io_port_block.sv]
// Two six-bit general purpose ports with direction control; pull-up and wake-on-change control on the first port only
//
// Behaviour
// - Port reads return live pin levels
// - First port: six bits, upper two read zero
// - Second port: same six-bit form
// - Pin three is input only, never driven
// - Alternate-function pins read as zero
// - Shared pull-up and wake enables for group
// - Reset pin: pull-up on, no wake
// - Timer clock overrides bit five direction
// - Direction load copies working register value
// - Direction one floats, zero drives latch
// - Direction write-only, all ones on reset
// - Latches hold; inputs are not latched
// - Each other pin has own direction
// - Status bit seven marks wake reset
// - Bit set/clear rewrites whole port latch
// - Write at cycle end, read at start
`include "six_bit_io_consts.svh"
module six_bit_io_port_block #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [4:0] ADDR_I,
  input wire logic WR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic BIT_OP_I,
  input wire logic BIT_VAL_I,
  input wire logic [2:0] BIT_SEL_I,
  input wire logic DIR_LOAD_I,
  input wire logic [2:0] DIR_SEL_I,
  input wire logic OPT_LOAD_I,
  input wire logic [7:0] W_I,
  input wire logic RESET_EVT_I,
  input wire logic RESET_BY_WAKE_I,
  input wire logic SLEEP_I,
  input wire logic CFG_EXT_RESET_I,
  input wire logic [5:0] CFG_ALT_I,
  input wire logic [5:0] FIRST_PIN_I,
  input wire logic [5:0] SECOND_PIN_I,
  output logic [7:0] RDATA_O,
  output logic [5:0] FIRST_PIN_O,
  output logic [5:0] FIRST_PIN_OE_O,
  output logic [5:0] FIRST_PULLUP_O,
  output logic [5:0] SECOND_PIN_O,
  output logic [5:0] SECOND_PIN_OE_O,
  output logic TIMER_CLK_O,
  output logic WAKE_O
);
  port_ctl_if first_if ();
  port_ctl_if second_if ();

  logic [7:0] options;
  logic wake_flag;
  logic [7:0] next_rdata;
  six_bit_io_pkg::pins_t group_mask;
  six_bit_io_pkg::pins_t first_alt;
  six_bit_io_pkg::pins_t second_alt;
  six_bit_io_pkg::pins_t first_read;
  six_bit_io_pkg::pins_t second_read;
  six_bit_io_pkg::pins_t wake_mask;
  six_bit_io_pkg::pins_t pullup_mask;
  logic t0cs;
  logic first_bitop;
  logic second_bitop;

  // =====================================
  // Helpers
  function automatic six_bit_io_pkg::pins_t port_view(
    input six_bit_io_pkg::pins_t pins,
    input six_bit_io_pkg::pins_t alt
  );
    port_view = pins & ~alt;
  endfunction : port_view

  function automatic six_bit_io_pkg::pins_t bit_modify(
    input six_bit_io_pkg::pins_t view,
    input logic [2:0] sel,
    input logic val
  );
    six_bit_io_pkg::pins_t res;
    res = view;
    if (sel < 3'h6) begin
      res[sel] = val;
    end
    bit_modify = res;
  endfunction : bit_modify

  // =====================================
  // Option register, loaded from the working register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      options <= `OPT_RESET;
    end else if (RESET_EVT_I) begin
      options <= `OPT_RESET;
    end else if (OPT_LOAD_I) begin
      options <= W_I;
    end
  end
  assign t0cs = options[`OPT_T0CS];

  // =====================================
  // Wake-reset flag in status bit seven
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wake_flag <= 1'b0;
    end else if (RESET_EVT_I) begin
      wake_flag <= RESET_BY_WAKE_I;
    end
  end

  // =====================================
  // Pin groups and overrides
  assign group_mask = LARGE_VARIANT ? `GROUP_LARGE : `GROUP_SMALL;
  assign first_alt = CFG_ALT_I | (CFG_EXT_RESET_I ? 6'h08 : 6'h00);
  assign second_alt = (LARGE_VARIANT && t0cs) ? 6'h20 : 6'h00;
  assign first_read = port_view(first_if.pins, first_alt);
  assign second_read = port_view(second_if.pins, second_alt);
  assign wake_mask = options[`OPT_WAKE_DIS] ? 6'h00
                   : (group_mask & (CFG_EXT_RESET_I ? 6'h37 : 6'h3F));
  assign pullup_mask = (options[`OPT_PULLUP_DIS] ? 6'h00 : group_mask)
                     | (CFG_EXT_RESET_I ? 6'h08 : 6'h00);
  assign FIRST_PULLUP_O = pullup_mask;
  assign TIMER_CLK_O = t0cs & second_if.pins[`PIN_FIVE];

  // =====================================
  // First port control
  assign first_bitop = BIT_OP_I && (ADDR_I == `ADDR_FIRST_PORT);
  assign first_if.wr = (WR_I && (ADDR_I == `ADDR_FIRST_PORT)) || first_bitop;
  assign first_if.wdata = first_bitop ? bit_modify(first_read, BIT_SEL_I, BIT_VAL_I)
                        : WDATA_I[5:0];
  assign first_if.dir_wr = DIR_LOAD_I && (DIR_SEL_I == `DIR_SEL_FIRST);
  assign first_if.dir_data = W_I[5:0];
  assign first_if.dir_rst = RESET_EVT_I;
  assign first_if.force_in = 6'h08;

  // =====================================
  // Second port control
  assign second_bitop = LARGE_VARIANT && BIT_OP_I && (ADDR_I == `ADDR_SECOND_PORT);
  assign second_if.wr = (LARGE_VARIANT && WR_I && (ADDR_I == `ADDR_SECOND_PORT))
                      || second_bitop;
  assign second_if.wdata = second_bitop ? bit_modify(second_read, BIT_SEL_I, BIT_VAL_I)
                         : WDATA_I[5:0];
  assign second_if.dir_wr = LARGE_VARIANT && DIR_LOAD_I
                          && (DIR_SEL_I == `DIR_SEL_SECOND);
  assign second_if.dir_data = W_I[5:0];
  assign second_if.dir_rst = RESET_EVT_I;
  assign second_if.force_in = !LARGE_VARIANT ? 6'h3F : (t0cs ? 6'h20 : 6'h00);

  // =====================================
  // Port banks
  io_port_bank u_first (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .bus(first_if.port),
    .pad_i(FIRST_PIN_I),
    .pad_o(FIRST_PIN_O),
    .pad_oe_o(FIRST_PIN_OE_O)
  );

  io_port_bank u_second (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .bus(second_if.port),
    .pad_i(SECOND_PIN_I),
    .pad_o(SECOND_PIN_O),
    .pad_oe_o(SECOND_PIN_OE_O)
  );

  // =====================================
  // Wake on pin change
  pin_wake_detect u_wake (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sleep_i(SLEEP_I),
    .mask_i(wake_mask),
    .pins_i(first_if.pins),
    .wake_o(WAKE_O)
  );

  // =====================================
  // Read path, sampled at the start of the instruction cycle
  always_comb begin
    next_rdata = 8'h00;
    case (ADDR_I)
      `ADDR_STATUS: begin
        next_rdata[`STAT_WAKE_BIT] = wake_flag;
      end
      `ADDR_FIRST_PORT: begin
        next_rdata = {2'b00, first_read};
      end
      `ADDR_SECOND_PORT: begin
        next_rdata = LARGE_VARIANT ? {2'b00, second_read} : 8'h00;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= next_rdata;
    end
  end

  // =====================================
  // Checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  AST_READ_PINS: assert property (
    (ADDR_I == `ADDR_FIRST_PORT) |=> (RDATA_O[5:0] == $past(first_if.pins & ~first_alt))
  ) else $error("first port read does not show pin levels");

  AST_UPPER_ZERO: assert property (
    (ADDR_I == `ADDR_FIRST_PORT) |=> (RDATA_O[7:6] == 2'b00)
  ) else $error("first port upper bits not zero");

  AST_SECOND_UPPER_ZERO: assert property (
    (ADDR_I == `ADDR_SECOND_PORT) |=> (RDATA_O[7:6] == 2'b00)
  ) else $error("second port upper bits not zero");

  AST_PIN3_INPUT: assert property (
    !FIRST_PIN_OE_O[`PIN_THREE]
  ) else $error("input-only pin driven");

  AST_ALT_ZERO: assert property (
    (ADDR_I == `ADDR_FIRST_PORT && CFG_ALT_I[0]) |=> (RDATA_O[0] == 1'b0)
  ) else $error("alternate function pin not read as zero");

  AST_PULLUP_GROUP: assert property (
    !options[`OPT_PULLUP_DIS] |-> ((FIRST_PULLUP_O & group_mask) == group_mask)
  ) else $error("group pull-ups not all on");

  AST_RESET_PIN_PULLUP: assert property (
    CFG_EXT_RESET_I |-> (FIRST_PULLUP_O[`PIN_THREE] && !wake_mask[`PIN_THREE])
  ) else $error("reset pin pull-up or wake wrong");

  AST_T0CK_OVERRIDE: assert property (
    (LARGE_VARIANT && t0cs) |-> !SECOND_PIN_OE_O[`PIN_FIVE]
  ) else $error("timer clock pin driven");

  AST_DIR_LOAD: assert property (
    (DIR_LOAD_I && DIR_SEL_I == `DIR_SEL_FIRST && !RESET_EVT_I)
    |=> (first_if.dir == $past(W_I[5:0]))
  ) else $error("direction load did not copy working register");

  AST_DRIVE_LATCH: assert property (
    (!first_if.dir[0]) |-> (FIRST_PIN_OE_O[0] && FIRST_PIN_O[0] == first_if.latch[0])
  ) else $error("output driver does not present latch");

  AST_DIR_RESET: assert property (
    RESET_EVT_I |=> (first_if.dir == `DIR_RESET && second_if.dir == `DIR_RESET)
  ) else $error("direction not set to inputs on reset");

  AST_LATCH_HOLD: assert property (
    !first_if.wr |=> $stable(first_if.latch)
  ) else $error("output latch changed without a write");

  AST_WAKE_FLAG: assert property (
    RESET_EVT_I |=> (wake_flag == $past(RESET_BY_WAKE_I))
    ##1 ($past(RESET_EVT_I) || $stable(wake_flag))
  ) else $error("wake flag does not follow reset cause");

  AST_BIT_RMW: assert property (
    (first_bitop && BIT_SEL_I == 3'h0)
    |=> (first_if.latch == {$past(first_read[5:1]), $past(BIT_VAL_I)})
  ) else $error("bit operation did not rewrite port latch");

  AST_WRITE_TIMING: assert property (
    (WR_I && ADDR_I == `ADDR_FIRST_PORT && !BIT_OP_I) |=> (first_if.latch == $past(WDATA_I[5:0]))
  ) else $error("port write not taken at cycle end");

  AST_SECOND_READ_PINS: assert property (
    (ADDR_I == `ADDR_SECOND_PORT) |=> (RDATA_O[5:0] == $past(second_if.pins & ~second_alt))
  ) else $error("second port read does not show pin levels");

  AST_TIMER_PIN_ZERO: assert property (
    (ADDR_I == `ADDR_SECOND_PORT && t0cs) |=> (RDATA_O[`PIN_FIVE] == 1'b0)
  ) else $error("timer clock pin not read as zero");

  AST_RESET_PIN_ZERO: assert property (
    (ADDR_I == `ADDR_FIRST_PORT && CFG_EXT_RESET_I) |=> (RDATA_O[`PIN_THREE] == 1'b0)
  ) else $error("reset pin not read as zero");

  AST_STATUS_READ: assert property (
    (ADDR_I == `ADDR_STATUS) |=> (RDATA_O == {$past(wake_flag), 7'h00})
  ) else $error("status read does not show wake flag");

  AST_FLOAT_INPUT: assert property (
    first_if.dir[0] |-> !FIRST_PIN_OE_O[0]
  ) else $error("output driver on while direction is input");

  AST_SECOND_DRIVE: assert property (
    !second_if.dir[0] |-> (SECOND_PIN_OE_O[0] && SECOND_PIN_O[0] == second_if.latch[0])
  ) else $error("second port driver does not present latch");

  AST_SECOND_DIR_LOAD: assert property (
    (LARGE_VARIANT && DIR_LOAD_I && DIR_SEL_I == `DIR_SEL_SECOND && !RESET_EVT_I)
    |=> (second_if.dir == $past(W_I[5:0]))
  ) else $error("second direction load did not copy working register");

  AST_SECOND_LATCH_HOLD: assert property (
    !second_if.wr |=> $stable(second_if.latch)
  ) else $error("second port latch changed without a write");

  AST_OPT_RESET: assert property (
    RESET_EVT_I |=> (options == `OPT_RESET)
  ) else $error("option register not restored on reset");

  AST_TIMER_CLK_IDLE: assert property (
    !t0cs |-> !TIMER_CLK_O
  ) else $error("timer clock passed while option is off");

  AST_WAKE_IN_SLEEP: assert property (
    WAKE_O |-> $past(SLEEP_I)
  ) else $error("wake pulse outside sleep");

  AST_WAKE_MASK_GROUP: assert property (
    (wake_mask & ~group_mask) == 6'h00
  ) else $error("wake enabled outside the shared group");

  AST_WAKE_ALL_GROUP: assert property (
    (!options[`OPT_WAKE_DIS] && !CFG_EXT_RESET_I) |-> (wake_mask == group_mask)
  ) else $error("shared wake enable does not cover the whole group");

  AST_SECOND_BIT_RMW: assert property (
    (second_bitop && BIT_SEL_I == 3'h5)
    |=> (second_if.latch == {$past(BIT_VAL_I), $past(second_read[4:0])})
  ) else $error("bit operation did not rewrite second port latch");

  AST_SECOND_WRITE_TIMING: assert property (
    (LARGE_VARIANT && WR_I && ADDR_I == `ADDR_SECOND_PORT && !BIT_OP_I)
    |=> (second_if.latch == $past(WDATA_I[5:0]))
  ) else $error("second port write not taken at cycle end");

  COV_BIT_OP: cover property (first_bitop ##1 first_if.wr);
  COV_WAKE_RESET: cover property (RESET_EVT_I && RESET_BY_WAKE_I);
  COV_DIR_THEN_DRIVE: cover property (first_if.dir_wr ##1 (FIRST_PIN_OE_O != 6'h00));
  COV_WAKE: cover property (SLEEP_I ##[1:20] WAKE_O);
  COV_T0CS_OFF: cover property (OPT_LOAD_I && !W_I[`OPT_T0CS]);
endmodule : six_bit_io_port_block

// [six_bit_io_port_block_tb.sv]
// Self-checking bench of the two-port I/O block
module six_bit_io_port_block_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_I = 0, RST_I = 1, WR_I = 0, BIT_OP_I = 0, BIT_VAL_I = 0, DIR_LOAD_I = 0;
  logic OPT_LOAD_I = 0, RESET_EVT_I = 0, RESET_BY_WAKE_I = 0, SLEEP_I = 0;
  logic CFG_EXT_RESET_I = 0, TIMER_CLK_O, WAKE_O, rd_req = 0, rd_tag = 0;
  logic [4:0] ADDR_I = 5'h00;
  logic [2:0] BIT_SEL_I = 3'h0, DIR_SEL_I = 3'h0;
  logic [7:0] WDATA_I = 8'h00, W_I = 8'h00, RDATA_O;
  logic [5:0] CFG_ALT_I = 6'h00, p1, p2, o1, o2, oe1, oe2, pu1, e1v = 6'h00, e2v = 6'h00;
  logic [5:0] e1e = 6'h3F, e2e = 6'h3F, ex;
  logic [31:0] v;
  logic [7:0] exp_q[$];
  int mismatches = 0, checks = 0, cycles = 0, wakes = 0;
  six_bit_io_port_block u_six_bit_io_port_block (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WR_I(WR_I), .WDATA_I(WDATA_I), .BIT_OP_I(BIT_OP_I),
    .BIT_VAL_I(BIT_VAL_I), .BIT_SEL_I(BIT_SEL_I), .DIR_LOAD_I(DIR_LOAD_I),
    .DIR_SEL_I(DIR_SEL_I), .OPT_LOAD_I(OPT_LOAD_I), .W_I(W_I), .RESET_EVT_I(RESET_EVT_I),
    .RESET_BY_WAKE_I(RESET_BY_WAKE_I), .SLEEP_I(SLEEP_I), .CFG_EXT_RESET_I(CFG_EXT_RESET_I),
    .CFG_ALT_I(CFG_ALT_I), .FIRST_PIN_I(p1), .SECOND_PIN_I(p2), .RDATA_O(RDATA_O),
    .FIRST_PIN_O(o1), .FIRST_PIN_OE_O(oe1), .FIRST_PULLUP_O(pu1), .SECOND_PIN_O(o2),
    .SECOND_PIN_OE_O(oe2), .TIMER_CLK_O(TIMER_CLK_O), .WAKE_O(WAKE_O));
  pin_world u_first_world (.clk_i(CLK_I), .drv_i(o1), .oe_i(oe1), .pu_i(pu1),
    .ext_val_i(e1v), .ext_en_i(e1e), .pad_o(p1));
  pin_world u_second_world (.clk_i(CLK_I), .drv_i(o2), .oe_i(oe2), .pu_i(6'h00),
    .ext_val_i(e2v), .ext_en_i(e2e), .pad_o(p2));
  always #25 CLK_I = ~CLK_I;
  // ==========================================
  // Checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge CLK_I) begin
    rd_tag <= rd_req;
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // Read data lands one edge after the address
  always @(negedge CLK_I) begin
    if (WAKE_O === 1'b1) begin
      wakes++;
    end
    if (rd_tag) begin
      chk(RDATA_O, exp_q.pop_front());
    end
  end
  // ==========================================
  // Drivers
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_I);
  endtask : cyc
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    ADDR_I = a;
    exp_q.push_back(e);
    rd_req = 1;
    cyc(1);
    rd_req = 0;
    cyc(1);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    ADDR_I = a;
    WDATA_I = d;
    WR_I = 1;
    cyc(1);
    WR_I = 0;
    cyc(1);
  endtask : wr
  task automatic dl(input logic [2:0] s, input logic [7:0] w);
    DIR_SEL_I = s;
    W_I = w;
    DIR_LOAD_I = 1;
    cyc(1);
    DIR_LOAD_I = 0;
    cyc(1);
  endtask : dl
  task automatic ol(input logic [7:0] w);
    W_I = w;
    OPT_LOAD_I = 1;
    cyc(1);
    OPT_LOAD_I = 0;
    cyc(1);
  endtask : ol
  task automatic bop(input logic [4:0] a, input logic [2:0] s, input logic b);
    ADDR_I = a;
    BIT_SEL_I = s;
    BIT_VAL_I = b;
    BIT_OP_I = 1;
    cyc(1);
    BIT_OP_I = 0;
    cyc(1);
  endtask : bop
  task automatic rev(input logic w);
    RESET_BY_WAKE_I = w;
    RESET_EVT_I = 1;
    cyc(1);
    RESET_EVT_I = 0;
    cyc(1);
  endtask : rev
  task automatic nap(input logic [5:0] nv, input logic [7:0] exp);
    SLEEP_I = 1;
    cyc(4);
    e1v = nv;
    cyc(6);
    SLEEP_I = 0;
    chk(8'(wakes), exp);
    cyc(2);
  endtask : nap
  // ==========================================
  // Scenarios
  initial begin
    repeat (16) @(posedge CLK_I);
    @(negedge CLK_I);
    RST_I = 0;
    v = $urandom(32'hAB37);
    chk(oe1, 8'h00);
    chk(oe2, 8'h00);
    rd(5'h03, 8'h00);
    rd(5'h1F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      e1v = v[5:0];
      e2v = v[13:8];
      cyc(3);
      rd(5'h06, {2'b00, e1v});
      rd(5'h07, {2'b00, e2v & 6'h1F});
      chk({7'h00, TIMER_CLK_O}, {7'h00, e2v[5]});
    end
    wr(5'h06, v[23:16]);
    chk(o1, v[21:16]);
    dl(3'h6, 8'h00);
    chk(oe1, 8'h37);
    e1e = 6'h08;
    cyc(3);
    rd(5'h06, {2'b00, (v[21:16] & 6'h37) | (e1v & 6'h08)});
    e1e = 6'h3F;
    e1v = ~v[21:16];
    cyc(3);
    rd(5'h06, {2'b00, e1v});
    for (int i = 0; i < 3; i++) begin
      ex = e1v;
      v = $urandom;
      ex[v[2:0] % 6] = v[8];
      bop(5'h06, 3'(v[2:0] % 6), v[8]);
      chk(o1, ex);
      dl(3'h6, v[23:16]);
      chk(oe1, ~v[21:16] & 6'h37);
      chk(o1, ex);
    end
    dl(3'h7, 8'h00);
    chk(oe2, 8'h1F);
    wr(5'h07, v[31:24]);
    chk(o2, v[29:24]);
    bop(5'h07, 3'h5, 1'b1);
    chk(o2, {1'b1, e2v[4:0]});
    ol(8'hDF);
    chk(oe2, 8'h3F);
    chk({7'h00, TIMER_CLK_O}, 8'h00);
    CFG_ALT_I = v[13:8];
    e1e = 6'h3F;
    cyc(3);
    rd(5'h06, {2'b00, e1v & ~v[13:8]});
    CFG_ALT_I = 6'h00;
    ol(8'h9F);
    chk(pu1, 8'h1B);
    CFG_EXT_RESET_I = 1;
    ol(8'h5F);
    chk(pu1, 8'h08);
    rd(5'h06, {2'b00, e1v & 6'h37});
    nap(e1v ^ 6'h08, 0);
    CFG_EXT_RESET_I = 0;
    nap(e1v ^ 6'h01, 1);
    rev(1);
    rd(5'h03, 8'h80);
    chk(oe1, 8'h00);
    rev(0);
    rd(5'h03, 8'h00);
    stop_test();
  end
endmodule : six_bit_io_port_block_tb
